//--- rsc_pkg.sv
// rsc_pkg: constants and types for the second-compensation / cal-out block
package rsc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] RSC_OFS_CTRL = 8'h00; // enable, period, source
	localparam logic [7:0] RSC_OFS_MOD = 8'h04; // second_modulo_value
	localparam logic [7:0] RSC_OFS_EXTRA = 8'h08; // extra-count field
	localparam logic [7:0] RSC_OFS_PIN = 8'h0C; // pin / route control
	localparam logic [7:0] RSC_OFS_TIME = 8'h10; // calendar counters
	localparam logic [7:0] RSC_OFS_STAT = 8'h14; // prescaler and cycle

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RSC_CTRL_EN_BIT = 0; // compensation enable
	localparam int RSC_CTRL_CCS_LSB = 1; // period select, two bits
	localparam int RSC_CTRL_SRC_BIT = 3; // cal_out_source_select
	localparam int RSC_PIN_OUT_BIT = 0; // pin_misc_control enable
	localparam int RSC_PIN_ROUTE_BIT = 1; // module_route_control bit
	localparam int RSC_TIME_MIN_LSB = 8; // minutes field
	localparam int RSC_TIME_HR_LSB = 16; // hours field
	localparam int RSC_STAT_CYC_LSB = 16; // cycle counter field

	// ------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] RSC_MOD_RST = 16'h8000; // 32768 counts
	localparam logic [7:0] RSC_EXTRA_RST = 8'h00;
	localparam logic [5:0] RSC_SEC_LAST = 6'h3B; // 59
	localparam logic [5:0] RSC_MIN_LAST = 6'h3B; // 59
	localparam logic [4:0] RSC_HR_LAST = 5'h17; // 23

	// compensation cycle lengths in seconds of the tick
	localparam logic [5:0] RSC_CCS_5 = 6'h05;
	localparam logic [5:0] RSC_CCS_15 = 6'h0F;
	localparam logic [5:0] RSC_CCS_30 = 6'h1E;
	localparam logic [5:0] RSC_CCS_60 = 6'h3C;

	// period select encodings
	typedef enum logic [1:0] {
		RSC_SEL_5S,
		RSC_SEL_15S,
		RSC_SEL_30S,
		RSC_SEL_60S
	} rsc_ccs_t;

endpackage

//--- rsc_sync.sv
// rsc_sync: two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module rsc_sync
	import rsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic async_in,
	output logic sync_out
);
	// first stage, read only by the second stage
	logic meta;

	// ------------------------------------------------------------
	// two-stage capture
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

//--- rsc_top.sv
// rsc_top: 1 Hz tick with fractional compensation and calibration output
`timescale 1ns/100ps
module rsc_top
	import rsc_pkg::*;
#(
	parameter int EXTRA_W = 8 // width of the extra-count field
)(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic counter_source_clock,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	output logic one_hz_tick,
	input wire logic cal_pin_in,
	output logic cal_pin_out,
	output logic cal_pin_oe_n,
	output logic timer_one_capture_one,
	output logic timer_one_capture_zero
);

	// ------------------------------------------------------------
	// software-visible state
	// ------------------------------------------------------------
	logic comp_en; // compensation enable
	rsc_ccs_t ccs_sel; // compensation period select
	logic cal_out_source_select; // 0 source clock, 1 tick
	logic [15:0] second_modulo_value; // integer count only
	logic [EXTRA_W-1:0] extra_count; // counts added per cycle
	logic pin_misc_control; // drive cal pin when set
	logic module_route_control; // route cal output to capture zero

	// ------------------------------------------------------------
	// counting state
	// ------------------------------------------------------------
	logic [15:0] second_prescale_counter;
	logic [5:0] cycle_count; // seconds into the compensation cycle
	logic [5:0] seconds_counter;
	logic [5:0] minutes_counter;
	logic [4:0] hours_counter;
	logic src_sync; // synchronised source clock level
	logic src_prev; // previous level for edge detection
	logic src_tick; // one cycle per source-clock rising edge
	logic [5:0] period; // selected cycle length
	logic terminal; // final second of the cycle
	logic [16:0] limit; // counts in the current second
	logic wrap; // prescaler wraps this cycle
	logic cal_level; // calibration signal before the pin
	logic half_level; // tick shown as a level, high first half

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	rsc_sync u_src_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in(counter_source_clock),
		.sync_out(src_sync)
	);

	// cal pin into the capture channel, synchronised like any pin
	rsc_sync u_cal_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in(cal_pin_in),
		.sync_out(timer_one_capture_one)
	);

	// ------------------------------------------------------------
	// source clock edge; the source must run below clk_sys / 4
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= src_sync;
		end
	end
	assign src_tick = src_sync & ~src_prev;

	// ------------------------------------------------------------
	// second length: extra counts only in the terminal second
	// ------------------------------------------------------------
	always_comb begin
		unique case (ccs_sel)
			RSC_SEL_5S: period = RSC_CCS_5;
			RSC_SEL_15S: period = RSC_CCS_15;
			RSC_SEL_30S: period = RSC_CCS_30;
			RSC_SEL_60S: period = RSC_CCS_60;
		endcase
	end
	// >= keeps a shortened period from stranding the counter
	assign terminal = (cycle_count >= period - 6'h01);
	// a second of mod + extra must not exceed 65536 counts
	assign limit = {1'b0, second_modulo_value} +
		((comp_en && terminal) ? 17'(extra_count) : 17'h00000);
	// >= so lowering the modulo mid-second wraps at the next source edge
	assign wrap = src_tick &&
		(({1'b0, second_prescale_counter} + 17'h00001) >= limit);

	// ------------------------------------------------------------
	// prescale counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			second_prescale_counter <= 16'h0000;
		end else if (wrap) begin
			second_prescale_counter <= 16'h0000;
		end else if (src_tick) begin
			second_prescale_counter <= second_prescale_counter + 16'h0001;
		end
	end

	// tick pulse, one clk_sys cycle per second
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			one_hz_tick <= 1'b0;
		end else begin
			one_hz_tick <= wrap;
		end
	end

	// ------------------------------------------------------------
	// compensation cycle counter, advanced by each wrap
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cycle_count <= 6'h00;
		end else if (wrap) begin
			// restart after the terminal second
			cycle_count <= terminal ? 6'h00 : cycle_count + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// calendar counters; a write to the time word loads them
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			seconds_counter <= 6'h00;
			minutes_counter <= 6'h00;
			hours_counter <= 5'h00;
		end else if (wr_stb && addr == RSC_OFS_TIME) begin
			seconds_counter <= wdata[5:0];
			minutes_counter <= wdata[RSC_TIME_MIN_LSB +: 6];
			hours_counter <= wdata[RSC_TIME_HR_LSB +: 5];
		end else if (wrap) begin
			if (seconds_counter >= RSC_SEC_LAST) begin
				seconds_counter <= 6'h00;
				if (minutes_counter >= RSC_MIN_LAST) begin
					minutes_counter <= 6'h00;
					if (hours_counter >= RSC_HR_LAST) begin
						hours_counter <= 5'h00;
					end else begin
						hours_counter <= hours_counter + 5'h01;
					end
				end else begin
					minutes_counter <= minutes_counter + 6'h01;
				end
			end else begin
				seconds_counter <= seconds_counter + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			comp_en <= 1'b0;
			ccs_sel <= RSC_SEL_5S;
			cal_out_source_select <= 1'b0;
			second_modulo_value <= RSC_MOD_RST;
			extra_count <= EXTRA_W'(RSC_EXTRA_RST);
			pin_misc_control <= 1'b0;
			module_route_control <= 1'b0;
		end else if (wr_stb) begin
			unique case (addr)
				RSC_OFS_CTRL: begin
					comp_en <= wdata[RSC_CTRL_EN_BIT];
					ccs_sel <= rsc_ccs_t'(wdata[RSC_CTRL_CCS_LSB +: 2]);
					cal_out_source_select <= wdata[RSC_CTRL_SRC_BIT];
				end
				// whole counts only, no fraction field exists
				RSC_OFS_MOD: second_modulo_value <= wdata[15:0];
				RSC_OFS_EXTRA: extra_count <= wdata[EXTRA_W-1:0];
				RSC_OFS_PIN: begin
					pin_misc_control <= wdata[RSC_PIN_OUT_BIT];
					module_route_control <= wdata[RSC_PIN_ROUTE_BIT];
				end
				default: ; // unmapped or read-only: ignored
			endcase
		end
	end

	// ------------------------------------------------------------
	// register read, data valid one cycle after the strobe only
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst || !rd_stb) begin
			rdata <= 32'h00000000;
		end else begin
			unique case (addr)
				RSC_OFS_CTRL: rdata <= {28'h0000000, cal_out_source_select,
					ccs_sel, comp_en};
				RSC_OFS_MOD: rdata <= {16'h0000, second_modulo_value};
				RSC_OFS_EXTRA: rdata <= 32'(extra_count);
				RSC_OFS_PIN: rdata <= {30'h00000000, module_route_control,
					pin_misc_control};
				RSC_OFS_TIME: rdata <= {11'h000, hours_counter, 2'h0,
					minutes_counter, 2'h0, seconds_counter};
				RSC_OFS_STAT: rdata <= {10'h000, cycle_count,
					second_prescale_counter};
				default: rdata <= 32'h00000000; // unmapped reads zero
			endcase
		end
	end

	// ------------------------------------------------------------
	// calibration output selection and routing
	// ------------------------------------------------------------
	// the tick is a one-cycle pulse; a half-second level is easier
	// for external equipment and capture channels to see
	assign half_level = (second_prescale_counter < (second_modulo_value >> 1));

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cal_level <= 1'b0;
		end else begin
			cal_level <= cal_out_source_select ? half_level : src_sync;
		end
	end

	assign cal_pin_out = cal_level & pin_misc_control;
	assign cal_pin_oe_n = ~pin_misc_control;
	assign timer_one_capture_zero = cal_level & module_route_control;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	AST_PERIOD_RESTART: assert property (
		wrap && cycle_count == period - 6'h01 |=> cycle_count == 6'h00)
		else $error("cycle counter did not restart at period end");
	AST_EXTRA_LAST: assert property (
		wrap && comp_en && terminal |-> second_prescale_counter + 17'h00001
		== {1'b0, second_modulo_value} + 17'(extra_count))
		else $error("terminal second not lengthened by extra count");
	AST_PLAIN_SECOND: assert property (
		src_tick && !terminal && second_prescale_counter + 17'h00001 ==
		{1'b0, second_modulo_value} |-> wrap)
		else $error("non-terminal second not at plain modulo");
	AST_MOD_WRITE: assert property (
		wr_stb && addr == RSC_OFS_MOD |=>
		second_modulo_value == $past(wdata[15:0]))
		else $error("modulo write not stored");
	AST_SRC_SEL: assert property (
		!cal_out_source_select |=> cal_level == $past(src_sync))
		else $error("cal output not following source clock");
	AST_PIN_OFF: assert property (
		!pin_misc_control |-> cal_pin_oe_n && !cal_pin_out)
		else $error("cal pin driven while disabled");
	AST_CAP_ONE: assert property (
		!$past(srst, 2) |-> timer_one_capture_one == $past(cal_pin_in, 2))
		else $error("capture one not fed from cal pin");
	AST_CAP_ZERO: assert property (
		timer_one_capture_zero == (module_route_control && cal_level))
		else $error("capture zero routing wrong");
	AST_SIXTY: assert property (
		ccs_sel == RSC_SEL_60S |-> period == RSC_CCS_60)
		else $error("sixty-second period not selected");
	AST_COUNT_UP: assert property (
		src_tick && !wrap |=> second_prescale_counter ==
		$past(second_prescale_counter) + 16'h0001)
		else $error("prescale counter failed to advance");
	AST_SEC_WRAP: assert property (
		wrap && seconds_counter == RSC_SEC_LAST &&
		!(wr_stb && addr == RSC_OFS_TIME) |=> seconds_counter == 6'h00)
		else $error("seconds did not return to zero after 59");
	AST_CYC_RANGE: assert property (
		$stable(ccs_sel) && $past(cycle_count) < period |-> cycle_count < period)
		else $error("cycle counter passed the period");
	AST_NO_COMP: assert property (
		wrap && !comp_en |-> second_prescale_counter + 17'h00001 >=
		{1'b0, second_modulo_value} && second_prescale_counter + 17'h00001
		<= {1'b0, second_modulo_value} + 17'h00001)
		else $error("extra counts used while compensation off");

	COV_COMP_WRAP: cover property (wrap && comp_en && terminal &&
		extra_count != '0);
	COV_TICK_SRC: cover property (cal_out_source_select && cal_pin_out);
	COV_HOUR_WRAP: cover property (wrap && hours_counter == RSC_HR_LAST &&
		minutes_counter == RSC_MIN_LAST && seconds_counter == RSC_SEC_LAST);
	COV_ROUTE: cover property (timer_one_capture_zero);

endmodule

//--- rsc_partner.sv
// rsc_partner: source clock and 1 Hz reference at the block's far side
`timescale 1ns/100ps
module rsc_partner #(
	// edges never land on a clk_sys rising edge, so sampling cannot race
	parameter real SRC_HALF = 412.0, // half period in ns, > 4 clk_sys
	parameter real REF_HALF = 3100.0 // reference half period in ns
)(
	input wire logic run, // source clock runs only while high
	output logic src_clk,
	output logic ref_level,
	output int n_edge
);
	// ------------------------------------------------------------
	// source clock
	// ------------------------------------------------------------
	// stands low while idle; edges counted so the bench can size seconds
	initial begin
		src_clk = 1'b0;
		n_edge = 0;
		forever begin
			#(SRC_HALF);
			if (run) begin
				src_clk = ~src_clk;
				n_edge = n_edge + int'(src_clk);
			end else begin
				src_clk = 1'b0;
			end
		end
	end
	// ------------------------------------------------------------
	// reference level offered on the shared pin
	// ------------------------------------------------------------
	// runs free: real references never stop for us
	initial begin
		ref_level = 1'b0;
		forever #(REF_HALF) ref_level = ~ref_level;
	end
endmodule

//--- tb.sv
// tb: self-checking bench for the compensated tick and calibration output
`timescale 1ns/100ps
module tb
	import rsc_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk_sys, srst, wr_stb, rd_stb, run;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rd;
	logic one_hz_tick, cal_pin_out, cal_pin_oe_n, cap_one, cap_zero;
	logic src_clk, ref_level;
	logic [15:0] mdl; // modulo under test
	logic [7:0] xtra; // extra counts under test
	int n_edge, n_mismatch, checks, last_edge;
	// wire level: the device wins only while it drives
	wire cal_wire = cal_pin_oe_n ? ref_level : cal_pin_out;

	rsc_top u_rsc_top (.clk_sys(clk_sys), .srst(srst),
		.counter_source_clock(src_clk), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.one_hz_tick(one_hz_tick), .cal_pin_in(cal_wire),
		.cal_pin_out(cal_pin_out), .cal_pin_oe_n(cal_pin_oe_n),
		.timer_one_capture_one(cap_one), .timer_one_capture_zero(cap_zero));
	rsc_partner u_rsc_partner (.run(run), .src_clk(src_clk),
		.ref_level(ref_level), .n_edge(n_edge));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic near(int a, int b);
		return (a - b <= 1) && (b - a <= 1); // edge counts may straddle
	endfunction
	function automatic int plen(int p);
		return (p == 0) ? 5 : (p == 1) ? 15 : (p == 2) ? 30 : 60;
	endfunction
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask
	task automatic rdr(logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		@(posedge clk_sys);
		d = rdata; // data stand only in this cycle
	endtask
	// source edges between two ticks, bounded wait
	task automatic wait_tick(output int len);
		int i;
		for (i = 0; i < 1000 && one_hz_tick !== 1'b1; i++) @(posedge clk_sys);
		if (i == 1000) begin
			n_mismatch++;
			$display("wrong value tick expected 1 seen 0");
			stop_test();
		end else begin
			len = n_edge - last_edge;
			last_edge = n_edge;
			@(posedge clk_sys);
		end
	endtask
	// watch the pin and both capture lines for 400 cycles
	task automatic watch(logic en, logic route, output int nw, nc, nt, nb);
		logic pw, pc;
		nw = 0;
		nc = 0;
		nt = 0;
		nb = 0;
		// let a new pin setting reach the wire and capture one first
		repeat (3) @(posedge clk_sys);
		pw = cal_wire;
		pc = cap_one;
		repeat (400) begin
			@(posedge clk_sys);
			nw += int'(cal_wire & ~pw);
			nc += int'(cap_one & ~pc);
			nt += int'(one_hz_tick === 1'b1);
			if (cap_zero !== (route & cal_pin_out)) nb++;
			if (cal_pin_oe_n !== ~en || (!en && cal_pin_out !== 1'b0)) nb++;
			pw = cal_wire;
			pc = cap_one;
		end
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n, len, nlong, ln, p, nw, nc, nt, nb, e0;
		srst = 1'b1;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		run = 1'b0;
		n_mismatch = 0;
		checks = 0;
		last_edge = 0;
		n = $urandom(32'h8F80311D);
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		rdr(RSC_OFS_CTRL, rd);
		check("ctrl", 32'h0, rd);
		rdr(RSC_OFS_MOD, rd);
		check("modulo", 32'h8000, rd);
		rdr(RSC_OFS_EXTRA, rd);
		check("extra", 32'h0, rd);
		rdr(8'h3C, rd);
		check("unmapped", 32'h0, rd);
		wr(RSC_OFS_STAT, 32'hFFFFFFFF);
		rdr(RSC_OFS_STAT, rd);
		check("status", 32'h0, rd);
		check("oe_n", 32'h1, cal_pin_oe_n);
		$display("test reset done");
		// compensation off: extra count must be ignored
		mdl = 16'(3 + $urandom_range(3));
		xtra = 8'(1 + $urandom_range(2));
		wr(RSC_OFS_MOD, {16'h0, mdl});
		wr(RSC_OFS_EXTRA, {24'h0, xtra});
		run <= 1'b1;
		wait_tick(len);
		for (n = 0; n < 6; n++) begin
			wait_tick(len);
			check("plain second", 32'(mdl), len);
		end
		$display("test plain done");
		// every period select, one long second per cycle
		for (p = 0; p < 4; p++) begin
			wr(RSC_OFS_CTRL, 32'(1 | (p << RSC_CTRL_CCS_LSB)));
			wait_tick(len);
			nlong = 0;
			ln = -1;
			for (n = 0; n < 2 * plen(p); n++) begin
				wait_tick(len);
				if (len == int'(mdl) + int'(xtra)) begin
					if (ln >= 0) check("long gap", plen(p), n - ln);
					ln = n;
					nlong++;
				end else begin
					check("short second", 32'(mdl), len);
				end
			end
			check("long seconds", 32'h2, nlong);
		end
		$display("test compensation done");
		// calendar wrap from the last hour
		wr(RSC_OFS_CTRL, 32'h0);
		wr(RSC_OFS_TIME, 32'h00173B3A);
		wait_tick(len);
		rdr(RSC_OFS_TIME, rd);
		check("time", 32'h00173B3B, rd);
		wait_tick(len);
		rdr(RSC_OFS_TIME, rd);
		check("time wrap", 32'h0, rd);
		$display("test calendar done");
		// pin released: the reference reaches capture one
		wr(RSC_OFS_PIN, 32'h0);
		watch(1'b0, 1'b0, nw, nc, nt, nb);
		check("pin idle", 32'h0, nb);
		check("ref edges", 32'h1, 32'(nw > 4));
		check("capture one", 32'h1, near(nw, nc));
		// source clock driven on the pin
		wr(RSC_OFS_PIN, 32'h1);
		e0 = n_edge;
		watch(1'b1, 1'b0, nw, nc, nt, nb);
		check("cal source", 32'h1, near(nw, n_edge - e0));
		check("pin driven", 32'h0, nb);
		check("capture one", 32'h1, near(nw, nc));
		// tick chosen first, then routed to capture zero
		wr(RSC_OFS_CTRL, 32'(1 << RSC_CTRL_SRC_BIT));
		wr(RSC_OFS_PIN, 32'h3);
		watch(1'b1, 1'b1, nw, nc, nt, nb);
		check("cal tick", 32'h1, near(nw, nt));
		check("route", 32'h0, nb);
		rdr(RSC_OFS_PIN, rd);
		check("pin word", 32'h3, rd);
		rdr(RSC_OFS_CTRL, rd);
		check("ctrl word", 32'(1 << RSC_CTRL_SRC_BIT), rd);
		$display("test calibration done");
		stop_test();
	end
endmodule
